// ==== src/asp_map.svh ====
// constants for the serial audio port: codes, offsets, timing counts
//
// Overview of operation
// - slave address comes from two strap pins: 0x10, 0x11, 0x40, 0x41.
// - a control bit selects master (drive bit clock, frame sync) or slave.
// - by default capture output is driven low while not sending channel data.
// - capture swap bit exchanges left and right capture channel contents.
// - sense mode sends sense data; format bit picks signed or unsigned.
// - playback path always carries ordinary audio samples.
// - port word length of 16, 20, 24 or 32 bits from a two-bit field.
// - companding bit forces an 8-bit word length.
// - tdm and pcm formats other than time slot carry eight channels on playback but only ch0 and ch1 on capture; time slot carries two.
// - format field: 00 rj, 01 lj, 10 i2s, 11 pcm; polarity picks pcm a/b.
// - left-justified: msb on first rise after sync change; ch0 sync high.
// - i2s: msb on second rise after sync change; left while sync low.
// - standard i2s: voltage-sense channel lags current-sense by one sample.
// - tdm lj: first-rise msb; odd channels sync low, even sync high.
// - tdm i2s: second-rise msb; even channels sync low, odd sync high.
// - pcm a: ch0 msb on second rise after sync pulse; rest back to back.
// - pcm b: ch0 msb on first rise after sync pulse; rest contiguous.
// - time slot: left and right delayed by 10-bit bit-clock counts.
// - with time slots on, pull enable/select give weak pulls; both zero gives high-z when idle.
// - with time slots on, release bit 0 holds last bit after a word unless pull enable and select are both zero; 1 floats the output.
// - pcm offset: ch0 msb at the left delay count; channels follow contiguous.
// - acknowledge an address byte only when it matches the strapped address.
`ifndef ASP_MAP_SVH
`define ASP_MAP_SVH
`define ASP_ADDR_LO_BASE 7'h10
`define ASP_ADDR_HI_BASE 7'h40
`define ASP_FMT_RJ 2'b00
`define ASP_FMT_LJ 2'b01
`define ASP_FMT_I2S 2'b10
`define ASP_FMT_PCM 2'b11
`define ASP_WL16 6'd16
`define ASP_WL20 6'd20
`define ASP_WL24 6'd24
`define ASP_WL32 6'd32
`define ASP_WL_CMB 6'd8
`define ASP_I2S_LEAD 11'd1
`define ASP_PCMA_LEAD 11'd1
`define ASP_TDM_SLOTS 4'd4
`define ASP_PCM_SLOTS 4'd8
`define ASP_MCLK_NS 100
`define ASP_BCLK_HALF_NS 400
`define ASP_BCLK_HALF_CYC ((`ASP_BCLK_HALF_NS + `ASP_MCLK_NS - 1) / `ASP_MCLK_NS)
`define ASP_FRAME_BITS 256
`define ASP_FIFO_DEPTH 16
`endif

// ==== src/asp_pkg.sv ====
// types shared by the serial audio port
package asp_pkg;
  typedef struct packed {
    logic port_master_select;
    logic capture_audio_mode;
    logic sense_unsigned_format;
    logic tdm_enable;
    logic capture_channel_swap;
    logic [1:0] word_length_field;
    logic companding_8bit_enable;
    logic [1:0] port_format_field;
    logic frame_polarity_select;
    logic offset_mode_enable;
    logic time_slot_enable;
    logic [9:0] left_slot_delay;
    logic [9:0] right_slot_delay;
    logic capture_pull_enable;
    logic capture_pull_select;
    logic capture_release_after_word;
  } asp_cfg_t;
  typedef struct packed {
    logic [31:0] left;
    logic [31:0] right;
  } asp_pair_t;
  typedef struct packed {
    logic [2:0] chan;
    logic [31:0] data;
  } asp_play_t;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_SHIFT = 2'b10
  } asp_tx_st_t;
endpackage

// ==== src/asp_top.sv ====
// serial audio port: capture fifo, frame timing, capture and playback paths, strap address
`timescale 1ns/100ps
`include "asp_map.svh"
module asp_fifo #(
  parameter int W = 64,
  parameter int D = `ASP_FIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  // depth must be a power of two: pointers wrap naturally
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0] wp_q;
  logic [AW:0] rp_q;
  assign in_ready = (wp_q - rp_q) != (AW+1)'(D);
  assign out_valid = wp_q != rp_q;
  assign out_data = mem[rp_q[AW-1:0]];
  always_ff @(posedge mclk) begin
    if (ce && in_valid && in_ready) begin
      mem[wp_q[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wp_q <= '0;
    end else if (ce && in_valid && in_ready) begin
      wp_q <= wp_q + 1'b1;
    end
  end
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rp_q <= '0;
    end else if (ce && out_valid && out_ready) begin
      rp_q <= rp_q + 1'b1;
    end
  end
endmodule

module asp_top #(
  parameter int BCLK_HALF = `ASP_BCLK_HALF_CYC,
  parameter int FRAME_BITS = `ASP_FRAME_BITS,
  parameter int FIFO_DEPTH = `ASP_FIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  input asp_pkg::asp_cfg_t cfg,
  input wire logic address_strap_low,
  input wire logic address_strap_high,
  output logic [6:0] slave_address_value,
  input wire logic i2c_addr_valid,
  input wire logic [7:0] i2c_addr_byte,
  output logic i2c_addr_ack,
  input wire logic bclk_in,
  output logic bclk_out,
  output logic bclk_oe,
  input wire logic fs_in,
  output logic fs_out,
  output logic fs_oe,
  input wire logic playback_serial_in,
  output logic capture_serial_out,
  output logic capture_oe,
  output logic capture_pull_up,
  output logic capture_pull_down,
  input wire logic cap_valid,
  output logic cap_ready,
  input asp_pkg::asp_pair_t cap_pair,
  input wire logic [15:0] sense_v_data,
  input wire logic [15:0] sense_i_data,
  output asp_pkg::asp_play_t play,
  output logic play_valid
);
  import asp_pkg::*;

  function automatic logic [5:0] asp_wlen(input logic [1:0] f, input logic cmb);
    if (cmb) begin
      asp_wlen = `ASP_WL_CMB;
    end else begin
      unique case (f)
        2'd0: asp_wlen = `ASP_WL16;
        2'd1: asp_wlen = `ASP_WL20;
        2'd2: asp_wlen = `ASP_WL24;
        2'd3: asp_wlen = `ASP_WL32;
      endcase
    end
  endfunction

  function automatic logic [2:0] asp_chan(input logic [3:0] slot, input logic flat, input logic odd);
    asp_chan = flat ? slot[2:0] : {slot[1:0], odd};
  endfunction

  // pin synchronisers: only stage [1] is read by logic
  logic [1:0] bclk_sy_q;
  logic [1:0] fs_sy_q;
  logic [1:0] din_sy_q;
  logic [1:0] strap_l_sy_q;
  logic [1:0] strap_h_sy_q;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      bclk_sy_q <= '0;
      fs_sy_q <= '0;
      din_sy_q <= '0;
      strap_l_sy_q <= '0;
      strap_h_sy_q <= '0;
    end else if (ce) begin
      bclk_sy_q <= {bclk_sy_q[0], bclk_in};
      fs_sy_q <= {fs_sy_q[0], fs_in};
      din_sy_q <= {din_sy_q[0], playback_serial_in};
      strap_l_sy_q <= {strap_l_sy_q[0], address_strap_low};
      strap_h_sy_q <= {strap_h_sy_q[0], address_strap_high};
    end
  end

  // strapped address and address-byte match
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      slave_address_value <= `ASP_ADDR_LO_BASE;
      i2c_addr_ack <= 1'b0;
    end else if (ce) begin
      slave_address_value <= (strap_h_sy_q[1] ? `ASP_ADDR_HI_BASE : `ASP_ADDR_LO_BASE) |
                             {6'h00, strap_l_sy_q[1]};
      i2c_addr_ack <= i2c_addr_valid && (i2c_addr_byte[7:1] == slave_address_value);
    end
  end

  logic pcm;
  logic ts;
  logic tdm;
  logic i2s_fmt;
  assign pcm = cfg.port_format_field == `ASP_FMT_PCM;
  assign ts = pcm && cfg.time_slot_enable;
  assign tdm = !pcm && cfg.tdm_enable;
  assign i2s_fmt = cfg.port_format_field == `ASP_FMT_I2S;

  // master clock and frame generation; sync changes on the falling bit clock
  logic ms_q;
  logic [7:0] div_q;
  logic mbclk_q;
  logic mfs_q;
  logic [9:0] fcnt_q;
  logic [9:0] fnext;
  assign fnext = (fcnt_q == 10'(FRAME_BITS - 1)) ? 10'h000 : fcnt_q + 1'b1;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ms_q <= 1'b0;
      div_q <= '0;
      mbclk_q <= 1'b0;
      mfs_q <= 1'b0;
      fcnt_q <= '0;
    end else if (ce) begin
      ms_q <= cfg.port_master_select;
      if (div_q == 8'(BCLK_HALF - 1)) begin
        div_q <= '0;
        mbclk_q <= !mbclk_q;
        if (mbclk_q) begin
          fcnt_q <= fnext;
          mfs_q <= pcm ? (fnext == 10'h000) : ((fnext < 10'(FRAME_BITS / 2)) ^ i2s_fmt);
        end
      end else begin
        div_q <= div_q + 1'b1;
      end
    end
  end
  assign bclk_out = mbclk_q;
  assign fs_out = mfs_q;
  assign bclk_oe = ms_q;
  assign fs_oe = ms_q;

  // edge finding on the selected bit clock
  logic bl;
  logic fl;
  logic bl_q;
  logic rise;
  logic fall;
  assign bl = ms_q ? mbclk_q : bclk_sy_q[1];
  assign fl = ms_q ? mfs_q : fs_sy_q[1];
  assign rise = ce && bl && !bl_q;
  assign fall = ce && !bl && bl_q;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      bl_q <= 1'b0;
    end else if (ce) begin
      bl_q <= bl;
    end
  end

  // frame position: rises counted from the last sync change, or in pcm from the last sync rise
  logic fs_last_q;
  logic [10:0] pos_q;
  logic [10:0] half_q;
  logic evt;
  logic even_half;
  logic frame_start;
  logic [10:0] pos;
  logic [5:0] wl;
  logic [3:0] nsl;
  logic [10:0] span;
  logic [10:0] start0;
  logic trig0;
  logic trig1;
  assign wl = asp_wlen(cfg.word_length_field, cfg.companding_8bit_enable);
  assign nsl = ts ? 4'd1 : pcm ? `ASP_PCM_SLOTS : tdm ? `ASP_TDM_SLOTS : 4'd1;
  assign evt = pcm ? (fl && !fs_last_q) : (fl != fs_last_q);
  assign even_half = i2s_fmt ? !fl : fl;
  assign frame_start = rise && evt && (pcm || even_half);
  assign pos = evt ? 11'h000 : ((pos_q == 11'h7ff) ? pos_q : pos_q + 1'b1);
  assign span = 11'(11'(wl) * 11'(nsl));
  always_comb begin
    unique case (cfg.port_format_field)
      `ASP_FMT_RJ: start0 = (half_q > span) ? 11'(half_q - span) : 11'h000;
      `ASP_FMT_LJ: start0 = 11'h000;
      `ASP_FMT_I2S: start0 = `ASP_I2S_LEAD;
      `ASP_FMT_PCM: begin
        if (cfg.offset_mode_enable || ts) begin
          start0 = 11'(cfg.left_slot_delay);
        end else begin
          start0 = cfg.frame_polarity_select ? 11'h000 : `ASP_PCMA_LEAD;
        end
      end
    endcase
  end
  assign trig0 = rise && (pos == start0);
  assign trig1 = rise && ts && (pos == 11'(cfg.right_slot_delay));
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pos_q <= 11'h7ff;
      fs_last_q <= 1'b0;
      half_q <= '0;
    end else if (rise) begin
      pos_q <= pos;
      fs_last_q <= fl;
      if (evt) begin
        half_q <= (pos_q == 11'h7ff) ? pos_q : pos_q + 1'b1;
      end
    end
  end

  // capture words for the frame: fifo audio or sense data
  logic fifo_valid;
  logic fifo_ready;
  asp_pair_t fifo_data;
  asp_fifo #(.W($bits(asp_pair_t)), .D(FIFO_DEPTH)) u_fifo (
    .mclk(mclk),
    .rstn(rstn),
    .ce(ce),
    .in_valid(cap_valid),
    .in_ready(cap_ready),
    .in_data(cap_pair),
    .out_valid(fifo_valid),
    .out_ready(fifo_ready),
    .out_data(fifo_data)
  );
  // an empty fifo at frame start sends silence rather than stalling the link
  assign fifo_ready = frame_start && cfg.capture_audio_mode;

  logic [15:0] v_prev_q;
  logic [15:0] sv;
  logic [15:0] si;
  asp_pair_t raw;
  asp_pair_t src;
  asp_pair_t pair_q;
  asp_pair_t cur;
  assign sv = ((i2s_fmt && !tdm) ? v_prev_q : sense_v_data) ^ {cfg.sense_unsigned_format, 15'h0000};
  assign si = sense_i_data ^ {cfg.sense_unsigned_format, 15'h0000};
  always_comb begin
    if (cfg.capture_audio_mode) begin
      raw = fifo_valid ? fifo_data : '0;
    end else begin
      raw = {sv, 16'h0000, si, 16'h0000};
    end
    src = cfg.capture_channel_swap ? {raw.right, raw.left} : raw;
  end
  assign cur = frame_start ? src : pair_q;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pair_q <= '0;
      v_prev_q <= '0;
    end else if (frame_start) begin
      pair_q <= src;
      v_prev_q <= sense_v_data;
    end
  end

  // slot sequencer shared by both paths
  asp_tx_st_t st_q;
  logic [5:0] bits_q;
  logic [3:0] slot_q;
  logic [2:0] ch_q;
  logic [31:0] sh_q;
  logic ld;
  logic [3:0] ld_slot;
  logic [2:0] ld_ch;
  logic own;
  logic sending;
  logic [31:0] word;
  always_comb begin
    ld = 1'b0;
    ld_slot = 4'd0;
    ld_ch = 3'd0;
    if (trig0) begin
      ld = 1'b1;
      ld_ch = ts ? 3'd0 : asp_chan(4'd0, pcm, !even_half);
    end else if (trig1) begin
      ld = 1'b1;
      ld_ch = 3'd1;
    end else if (rise && st_q == TX_SHIFT && bits_q == 6'd1 && (slot_q + 1'b1) < nsl) begin
      ld = 1'b1;
      ld_slot = slot_q + 1'b1;
      ld_ch = asp_chan(ld_slot, pcm, !even_half);
    end
  end
  // only the two converter channels are ours; other slots belong to other talkers
  assign own = ld && (ld_ch < 3'd2);
  assign word = (ld_ch == 3'd0) ? cur.left : cur.right;
  assign sending = (st_q == TX_SHIFT) && (ch_q < 3'd2);
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_q <= TX_IDLE;
      bits_q <= '0;
      slot_q <= '0;
      ch_q <= '0;
      sh_q <= '0;
    end else if (rise) begin
      if (ld) begin
        st_q <= TX_SHIFT;
        bits_q <= wl;
        slot_q <= ld_slot;
        ch_q <= ld_ch;
        sh_q <= word;
      end else if (st_q == TX_SHIFT) begin
        sh_q <= {sh_q[30:0], 1'b0};
        if (bits_q == 6'd1) begin
          st_q <= TX_IDLE;
        end else begin
          bits_q <= bits_q - 1'b1;
        end
      end
    end
  end

  // capture pin: bit value and drive window
  logic out_q;
  logic drv_q;
  logic float_idle;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      out_q <= 1'b0;
      drv_q <= 1'b0;
    end else begin
      if (own) begin
        out_q <= word[31];
        drv_q <= 1'b1;
      end else if (rise && sending && bits_q != 6'd1) begin
        out_q <= sh_q[30];
      end else if (rise && sending && !ts) begin
        // word over: low from the next bit time, not only after the release fall
        out_q <= 1'b0;
      end else if (fall && !sending) begin
        drv_q <= 1'b0;
      end
    end
  end
  // the extra pin states only exist with time slots on
  assign float_idle = ts && (cfg.capture_release_after_word ||
                      (!cfg.capture_pull_enable && !cfg.capture_pull_select));
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      capture_serial_out <= 1'b0;
      capture_oe <= 1'b1;
      capture_pull_up <= 1'b0;
      capture_pull_down <= 1'b0;
    end else if (ce) begin
      capture_pull_up <= ts && cfg.capture_pull_enable && cfg.capture_pull_select;
      capture_pull_down <= ts && cfg.capture_pull_enable && !cfg.capture_pull_select;
      if (drv_q) begin
        capture_serial_out <= out_q;
        capture_oe <= 1'b1;
      end else if (!ts) begin
        capture_serial_out <= 1'b0;
        capture_oe <= 1'b1;
      end else begin
        capture_serial_out <= out_q;
        capture_oe <= !float_idle;
      end
    end
  end

  // playback receive: sampled on the falling edge mid bit, always audio
  logic [31:0] rx_q;
  logic [31:0] rx_nxt;
  assign rx_nxt = {rx_q[30:0], din_sy_q[1]};
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rx_q <= '0;
      play <= '0;
      play_valid <= 1'b0;
    end else if (ce) begin
      play_valid <= 1'b0;
      if (fall && st_q == TX_SHIFT) begin
        rx_q <= rx_nxt;
        if (bits_q == 6'd1) begin
          play.data <= rx_nxt << (6'd32 - wl);
          play.chan <= ch_q;
          play_valid <= 1'b1;
        end
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  property p_addr;
    ce && strap_h_sy_q[1] && !strap_l_sy_q[1] |=> slave_address_value == 7'h40;
  endproperty
  a_addr: assert property (p_addr) else $error("strap 10 did not give address 0x40");
  property p_ack_hit;
    ce && i2c_addr_valid && i2c_addr_byte[7:1] == slave_address_value |=> i2c_addr_ack;
  endproperty
  a_ack_hit: assert property (p_ack_hit) else $error("matching address not acknowledged");
  property p_ack_miss;
    ce && !(i2c_addr_valid && i2c_addr_byte[7:1] == slave_address_value) |=> !i2c_addr_ack;
  endproperty
  a_ack_miss: assert property (p_ack_miss) else $error("acknowledge without a matching address");
  property p_slave;
    ce && !cfg.port_master_select |=> !bclk_oe && !fs_oe;
  endproperty
  a_slave: assert property (p_slave) else $error("clock pins driven in slave mode");
  property p_idle_low;
    ce && !ts && !drv_q |=> capture_oe && !capture_serial_out;
  endproperty
  a_idle_low: assert property (p_idle_low) else $error("capture not driven low while idle");
  property p_swap;
    frame_start && cfg.capture_audio_mode && cfg.capture_channel_swap && fifo_valid
      |=> pair_q.left == $past(fifo_data.right);
  endproperty
  a_swap: assert property (p_swap) else $error("capture channels not swapped");
  property p_unsigned;
    frame_start && !cfg.capture_audio_mode && cfg.sense_unsigned_format && !cfg.capture_channel_swap
      |=> pair_q.right[31] == !$past(sense_i_data[15]);
  endproperty
  a_unsigned: assert property (p_unsigned) else $error("unsigned sense sign bit wrong");
  property p_wl32;
    ld && !cfg.companding_8bit_enable && cfg.word_length_field == 2'd3 |=> bits_q == 6'd32;
  endproperty
  a_wl32: assert property (p_wl32) else $error("code 3 did not give 32-bit words");
  property p_cmb;
    ld && cfg.companding_8bit_enable |=> bits_q == 6'd8;
  endproperty
  a_cmb: assert property (p_cmb) else $error("companding did not give 8-bit words");
  property p_lj;
    rise && evt && cfg.port_format_field == `ASP_FMT_LJ |-> ld && ld_ch == {2'b00, !fl};
  endproperty
  a_lj: assert property (p_lj) else $error("left-justified msb not on first rise");
  property p_i2s;
    rise && i2s_fmt && !tdm && pos == 11'd1 |-> ld && ld_ch == {2'b00, fl};
  endproperty
  a_i2s: assert property (p_i2s) else $error("i2s msb not on second rise");
  property p_release;
    ce && ts && cfg.capture_release_after_word && !drv_q |=> !capture_oe;
  endproperty
  a_release: assert property (p_release) else $error("capture still driven after release");

  c_ch7: cover property (ld && ld_ch == 3'd7);
  c_ts_right: cover property (trig1);
  c_play: cover property (play_valid && play.chan == 3'd1);
  c_master_frame: cover property (frame_start && ms_q);
endmodule

// ==== dv/asp_host_model.sv ====
// host side of the audio link: bit clock, frame sync, playback bits, capture bit collection
`timescale 1ns/100ps
module asp_host_model (
  input wire logic pcm,
  input wire logic [31:0] play_word,
  input wire logic cap_bit,
  input wire logic [7:0] want,
  output logic bclk,
  output logic fs,
  output logic sdin,
  output logic [63:0] cap,
  output logic [7:0] frames
);
  int n;
  initial begin
    bclk = 1'b0;
    fs = 1'b0;
    sdin = 1'b0;
    cap = '0;
    frames = 8'h00;
    forever begin
      wait (frames < want);
      #100;
      for (n = 0; n < 64; n++) begin
        // sync and data change mid low phase, clear of both clock edges
        fs = pcm ? (n == 0) : (n < 32);
        sdin = play_word[31 - n % 32];
        #200 bclk = 1'b1;
        #400 bclk = 1'b0;
        // device launches a few mclk after the rise, so sample 150 ns after the fall, early in the low phase
        #150 cap = {cap[62:0], cap_bit};
        #50;
      end
      // clock stands still between frames; data no longer valid
      sdin = ~sdin;
      frames = frames + 8'h01;
    end
  end
endmodule

// ==== dv/tb.sv ====
// testbench for the serial audio port: strap address, capture fifo, frame formats, playback, master mode
`timescale 1ns/100ps
module tb;
  import asp_pkg::*;
  logic mclk, rstn, cap_valid, i2c_addr_valid, sl, sh, pcm, i2c_addr_ack, bclk_out, bclk_oe, fs_out, fs_oe;
  logic capture_serial_out, capture_oe, capture_pull_up, capture_pull_down, cap_ready, play_valid;
  logic bclk, fs, sdin, rdy;
  logic [6:0] slave_address_value, a;
  logic [7:0] i2c_addr_byte, want, frames;
  logic [15:0] sv, si;
  logic [31:0] play_word, m;
  logic [63:0] cap, e;
  asp_cfg_t cfg;
  asp_pair_t cap_pair, p;
  asp_play_t play;
  asp_play_t rq[$];
  asp_pair_t pq[$];
  int fails = 0, checked = 0, cyc = 0, k, n, w;
  int wlt[4] = '{16, 20, 24, 32};

  asp_top #(.FRAME_BITS(64)) asp_top_i (.mclk(mclk), .rstn(rstn), .ce(1'b1), .cfg(cfg), .address_strap_low(sl),
    .address_strap_high(sh), .slave_address_value(slave_address_value), .i2c_addr_valid(i2c_addr_valid),
    .i2c_addr_byte(i2c_addr_byte), .i2c_addr_ack(i2c_addr_ack), .bclk_in(bclk), .bclk_out(bclk_out),
    .bclk_oe(bclk_oe), .fs_in(fs), .fs_out(fs_out), .fs_oe(fs_oe), .playback_serial_in(sdin),
    .capture_serial_out(capture_serial_out), .capture_oe(capture_oe), .capture_pull_up(capture_pull_up),
    .capture_pull_down(capture_pull_down), .cap_valid(cap_valid), .cap_ready(cap_ready), .cap_pair(cap_pair),
    .sense_v_data(sv), .sense_i_data(si), .play(play), .play_valid(play_valid));
  asp_host_model asp_host_model_i (.pcm(pcm), .play_word(play_word),
    .cap_bit(capture_oe ? capture_serial_out : capture_pull_up), .want(want), .bclk(bclk), .fs(fs),
    .sdin(sdin), .cap(cap), .frames(frames));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    if (play_valid === 1'b1) rq.push_back(play);
  end

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fails++;
      summarize();
    end
  end

  task automatic summarize;
    $display("compares %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic send(input logic [6:0] ad, input logic ex);
    i2c_addr_byte <= {ad, ex};
    i2c_addr_valid <= 1'b1;
    @(posedge mclk);
    i2c_addr_valid <= 1'b0;
    @(negedge mclk);
    chk(i2c_addr_ack, ex);
    @(posedge mclk);
  endtask

  // holds valid across the whole burst, so a full fifo stalls the source
  task automatic push(input int cnt);
    cap_valid <= 1'b1;
    cap_pair <= {$urandom, $urandom};
    for (n = 0; n < cnt; n++) begin
      @(negedge mclk);
      rdy = cap_ready;
      @(posedge mclk);
      if (rdy === 1'b1) begin
        pq.push_back(cap_pair);
        cap_pair <= {$urandom, $urandom};
      end
    end
    cap_valid <= 1'b0;
  endtask

  task automatic frame(input int nch, input int sft);
    rq.delete();
    want <= want + 8'd1;
    play_word <= $urandom;
    @(posedge mclk);
    for (n = 0; n < 9000 && frames != want; n++) @(posedge mclk);
    repeat (12) @(posedge mclk);
    if (nch > 0) chk(rq.size(), nch);
    for (n = 0; n < nch; n++) chk({rq[n].chan, rq[n].data & m}, {n[2:0], (play_word << (sft * n % 32)) & m});
  endtask

  initial begin
    rstn = 1'b0;
    cfg = '0;
    cap_valid = 1'b0;
    cap_pair = '0;
    i2c_addr_valid = 1'b0;
    i2c_addr_byte = 8'h00;
    {sh, sl} = 2'b00;
    pcm = 1'b0;
    want = 8'h00;
    sv = 16'h0000;
    si = 16'h0000;
    play_word = 32'h0;
    k = $urandom(68873);
    cfg.capture_audio_mode = 1'b1;
    cfg.port_format_field = 2'b01;
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    for (k = 0; k < 4; k++) begin
      {sh, sl} <= k[1:0];
      repeat (5) @(posedge mclk);
      a = (k[1] ? 7'h40 : 7'h10) | 7'(k[0]);
      chk(slave_address_value, a);
      send(a, 1'b1);
      send(a ^ 7'h01, 1'b0);
    end
    $display("test address done");
    m = 32'h0;
    frame(0, 0);
    push(24);
    chk(pq.size(), 16);
    @(negedge mclk);
    chk(cap_ready, 1'b0);
    @(posedge mclk);
    for (k = 0; k < 16; k++) begin
      cfg.word_length_field <= k[1:0];
      cfg.capture_channel_swap <= k[2];
      cfg.companding_8bit_enable <= (k == 15);
      w = (k == 15) ? 8 : wlt[k % 4];
      m = ~(32'hffffffff >> w);
      p = pq.pop_front();
      frame(2, 0);
      chk(cap, k[2] ? {p.right & m, p.left & m} : {p.left & m, p.right & m});
    end
    chk(cap_ready, 1'b1);
    $display("test capture formats done");
    cfg.capture_audio_mode <= 1'b0;
    cfg.word_length_field <= 2'd0;
    cfg.capture_channel_swap <= 1'b0;
    cfg.companding_8bit_enable <= 1'b0;
    m = 32'hffff0000;
    for (k = 0; k < 2; k++) begin
      cfg.sense_unsigned_format <= k[0];
      sv <= 16'($urandom);
      si <= 16'($urandom);
      frame(2, 0);
      chk(cap, {sv ^ {k[0], 15'h0}, 16'h0, si ^ {k[0], 15'h0}, 16'h0});
    end
    $display("test sense data done");
    cfg.capture_audio_mode <= 1'b1;
    cfg.port_format_field <= 2'b11;
    cfg.companding_8bit_enable <= 1'b1;
    pcm <= 1'b1;
    m = 32'hff000000;
    for (k = 1; k >= 0; k--) begin
      cfg.frame_polarity_select <= k[0];
      push(1);
      p = pq.pop_front();
      frame(k * 8, 8);
      e = {p.left[31:24], p.right[31:24], 48'h0};
      chk(cap, e >> (1 - k));
    end
    $display("test pcm done");
    pcm <= 1'b0;
    cfg.port_format_field <= 2'b01;
    cfg.tdm_enable <= 1'b1;
    push(1);
    p = pq.pop_front();
    frame(0, 0);
    chk(rq.size(), 8);
    chk({rq[1].chan, rq[1].data & m}, {3'd2, (play_word << 8) & m});
    chk({rq[4].chan, rq[4].data & m}, {3'd1, play_word & m});
    chk(cap, {p.left[31:24], 24'h0, p.right[31:24], 24'h0});
    $display("test tdm done");
    cfg.tdm_enable <= 1'b0;
    cfg.port_format_field <= 2'b10;
    frame(0, 0);
    chk(rq.size(), 2);
    chk({rq[0].chan, rq[0].data & m}, {3'd1, (play_word << 1) & m});
    chk({rq[1].chan, rq[1].data & m}, {3'd0, (play_word << 1) & m});
    $display("test i2s done");
    cfg.port_format_field <= 2'b01;
    cfg.port_master_select <= 1'b1;
    repeat (20) @(posedge mclk);
    chk({bclk_oe, fs_oe}, 2'b11);
    w = 0;
    @(negedge mclk);
    a[0] = bclk_out;
    for (k = 0; k < 64; k++) begin
      @(negedge mclk);
      if (bclk_out !== a[0]) w++;
      a[0] = bclk_out;
    end
    chk(w, 16);
    @(posedge mclk);
    cfg.port_master_select <= 1'b0;
    repeat (4) @(posedge mclk);
    chk({bclk_oe, fs_oe}, 2'b00);
    $display("test master done");
    rstn <= 1'b0;
    repeat (3) @(posedge mclk);
    chk(slave_address_value, 7'h10);
    chk(cap_ready, 1'b1);
    rstn <= 1'b1;
    $display("test second reset done");
    summarize();
  end
endmodule
